// ---- logic/acr_algorithm_clock_reset_control.sv ----
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
module acr_algorithm_clock_reset_control #(
  parameter int RATE_MHZ    = 200,
  parameter int LOCK_CYCLES = acr_pkg::LOCK_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  // system port reset pin
  input  wire logic                          portResetIn,
  // register port
  input  wire logic [acr_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [acr_pkg::DATA_W-1:0]    regWdata,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  output logic      [acr_pkg::DATA_W-1:0]    regRdata,
  // algorithm side
  input  wire logic                          algDone,
  output logic                               algClkEnable,
  output logic                               algEdge,
  output logic                               algRst,
  // chip resets
  output logic                               fullRst,
  output logic                               coreRst
);

  localparam int DIV = acr_pkg::div_ratio(RATE_MHZ);

  // ----------------------------------------------------------------
  // build-time rate check
  // ----------------------------------------------------------------
  if (RATE_MHZ != 50 && RATE_MHZ != 66 && RATE_MHZ != 100
      && RATE_MHZ != 200) begin : g_bad_rate
    $error("acr: rate must be 50, 66, 100 or 200");
  end

  logic                  locked;
  logic                  undivTick;
  logic                  divTick;
  logic                  tick;
  logic                  portRstMeta;
  logic                  portRstSync;
  logic                  coreRstMeta;
  logic                  next_fullRst;
  acr_pkg::acr_state_type state;
  acr_pkg::acr_state_type next_state;
  logic [2:0]            pulseCnt;
  logic [2:0]            next_pulseCnt;
  logic                  next_algRst;
  logic                  next_algClkEnable;
  logic                  next_algEdge;
  logic                  startPend;
  logic                  next_startPend;
  logic                  doneFlag;
  logic                  next_doneFlag;
  logic                  started;
  logic                  next_started;
  logic [acr_pkg::DATA_W-1:0] next_regRdata;
  logic                  startWr;
  logic                  doneClrWr;
  acr_pkg::acr_status_type status;

  // ----------------------------------------------------------------
  // clock manager
  // ----------------------------------------------------------------
  acr_clock_manager #(
    .DIV_RATIO   (DIV),
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_manager (
    .ref_clk     (ref_clk),
    .portResetIn (portResetIn),
    .locked      (locked),
    .undivTick   (undivTick),
    .divTick     (divTick)
  );

  // at 200 the undivided output is the algorithm clock
  assign tick = (RATE_MHZ == acr_pkg::CORE_MHZ) ? undivTick : divTick;

  // ----------------------------------------------------------------
  // reset chain
  // ----------------------------------------------------------------
  always_comb begin
    next_fullRst = portRstSync | ~locked;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      portRstMeta <= 1'b1;
      portRstSync <= 1'b1;
      fullRst     <= 1'b1;
      coreRstMeta <= 1'b1;
      coreRst     <= 1'b1;
    end else begin
      portRstMeta <= portResetIn;
      portRstSync <= portRstMeta;
      fullRst     <= next_fullRst;
      coreRstMeta <= fullRst;
      coreRst     <= coreRstMeta;
    end
  end

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  assign startWr   = regWrite && regAddr == acr_pkg::CTRL_OFF
                     && regWdata[acr_pkg::CTRL_START_BIT];
  assign doneClrWr = regWrite && regAddr == acr_pkg::CTRL_OFF
                     && regWdata[acr_pkg::CTRL_DONE_CLR_BIT];

  always_comb begin
    status.started = started;
    status.done    = doneFlag;
    status.coreRst = coreRst;
    status.locked  = locked;
    status.algRst  = algRst;
    status.running = (state == acr_pkg::ST_RUN) || (state == acr_pkg::ST_PULSE);
    next_regRdata  = acr_pkg::REG_RESET;
    if (regRead) begin
      case (regAddr)
        acr_pkg::CTRL_OFF: begin
          next_regRdata = acr_pkg::REG_RESET; // start is self clearing
        end
        acr_pkg::STATUS_OFF: begin
          next_regRdata = {(acr_pkg::DATA_W - acr_pkg::STATUS_W)'(0), status};
        end
        acr_pkg::RATE_OFF: begin
          next_regRdata = (acr_pkg::DATA_W)'(RATE_MHZ);
        end
        default: begin
          next_regRdata = acr_pkg::REG_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // algorithm controller
  // ----------------------------------------------------------------
  // outside core reset, algRst and algClkEnable move only on a tick (algEdge drops the cycle after),
  // so a slow algorithm clock never sees a change between its own edges
  always_comb begin
    next_state        = state;
    next_pulseCnt     = pulseCnt;
    next_algRst       = algRst;
    next_algClkEnable = algClkEnable;
    next_startPend    = startPend;
    next_doneFlag     = doneFlag;
    next_started      = started;
    // a start waits for the next algorithm edge
    if (tick && startPend) begin
      next_startPend = 1'b0;
    end
    if (startWr) begin
      next_startPend = 1'b1; // set wins over consume
    end
    if (doneClrWr) begin
      next_doneFlag = 1'b0;
    end
    if (tick) begin
      case (state)
        acr_pkg::ST_HOLD, acr_pkg::ST_IDLE, acr_pkg::ST_RUN: begin
          if (startPend) begin
            next_state        = acr_pkg::ST_PULSE;
            next_pulseCnt     = 3'h0;
            next_algRst       = 1'b1;
            next_algClkEnable = 1'b1;
            next_started      = 1'b1;
          end else if (state == acr_pkg::ST_RUN && algDone) begin
            next_state        = acr_pkg::ST_IDLE;
            next_algClkEnable = 1'b0;
            next_algRst       = 1'b0;
            next_doneFlag     = 1'b1; // set wins over clear
          end
        end
        acr_pkg::ST_PULSE: begin
          next_pulseCnt = pulseCnt + 3'h1;
          if (pulseCnt == acr_pkg::ALG_RST_LAST) begin
            next_state  = acr_pkg::ST_RUN;
            next_algRst = 1'b0;
          end
        end
        default: begin
          next_state = acr_pkg::ST_HOLD;
        end
      endcase
    end
    next_algEdge = tick && next_algClkEnable;
    if (coreRst) begin
      next_state        = acr_pkg::ST_HOLD;
      next_pulseCnt     = 3'h0;
      next_algRst       = 1'b1;
      next_algClkEnable = 1'b0;
      next_algEdge      = 1'b0;
      next_startPend    = 1'b0;
      next_doneFlag     = 1'b0;
      next_started      = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state        <= acr_pkg::ST_HOLD;
      pulseCnt     <= 3'h0;
      algRst       <= 1'b1;
      algClkEnable <= 1'b0;
      algEdge      <= 1'b0;
      startPend    <= 1'b0;
      doneFlag     <= 1'b0;
      started      <= 1'b0;
      regRdata     <= acr_pkg::REG_RESET;
    end else begin
      state        <= next_state;
      pulseCnt     <= next_pulseCnt;
      algRst       <= next_algRst;
      algClkEnable <= next_algClkEnable;
      algEdge      <= next_algEdge;
      startPend    <= next_startPend;
      doneFlag     <= next_doneFlag;
      started      <= next_started;
      regRdata     <= next_regRdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] sinceTick;
  logic       seenTick;

  always_ff @(posedge ref_clk) begin
    if (rst || !locked) begin
      sinceTick <= 3'h0;
      seenTick  <= 1'b0;
    end else if (tick) begin
      sinceTick <= 3'h0;
      seenTick  <= 1'b1;
    end else begin
      sinceTick <= sinceTick + 3'h1;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  property p_full_on_unlock;
    !locked |=> fullRst;
  endproperty
  a_full_on_unlock: assert property (p_full_on_unlock)
    else $error("full reset missing while unlocked");

  property p_core_follows_full;
    fullRst |-> ##2 coreRst;
  endproperty
  a_core_follows_full: assert property (p_core_follows_full)
    else $error("core reset did not follow full reset");

  property p_manager_reset;
    portRstSync |-> !locked;
  endproperty
  a_manager_reset: assert property (p_manager_reset)
    else $error("manager locked during pin reset");

  property p_hold_until_start;
    (state == acr_pkg::ST_HOLD) |-> algRst && !started;
  endproperty
  a_hold_until_start: assert property (p_hold_until_start)
    else $error("algorithm reset released before first start");

  property p_pulse_length;
    $fell(algRst) |-> $past(pulseCnt) == acr_pkg::ALG_RST_LAST
                      && $past(state) == acr_pkg::ST_PULSE;
  endproperty
  a_pulse_length: assert property (p_pulse_length)
    else $error("reset pulse length not four algorithm cycles");

  property p_rst_on_edge;
    ($changed(algRst) && !$past(coreRst)) |-> $past(tick);
  endproperty
  a_rst_on_edge: assert property (p_rst_on_edge)
    else $error("algorithm reset moved between algorithm edges");

  property p_enable_in_pulse;
    (state == acr_pkg::ST_PULSE) |-> algClkEnable && algRst;
  endproperty
  a_enable_in_pulse: assert property (p_enable_in_pulse)
    else $error("clock gated during reset pulse");

  property p_idle_out_of_reset;
    (state == acr_pkg::ST_IDLE) |-> !algRst && !algClkEnable;
  endproperty
  a_idle_out_of_reset: assert property (p_idle_out_of_reset)
    else $error("algorithm reset after run completion");

  property p_tick_period;
    (tick && seenTick && locked) |-> sinceTick == 3'(DIV - 1);
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("algorithm edge period wrong");

  property p_enable_active;
    algClkEnable |-> (state == acr_pkg::ST_PULSE || state == acr_pkg::ST_RUN);
  endproperty
  a_enable_active: assert property (p_enable_active)
    else $error("clock enabled while inactive");

  property p_core_tick;
    locked && $past(locked) |-> undivTick;
  endproperty
  a_core_tick: assert property (p_core_tick)
    else $error("core tick missing while locked");

  property p_read_status;
    regRead && regAddr == acr_pkg::STATUS_OFF |=> regRdata[1] == $past(algRst);
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("status read wrong");

  c_first_start: cover property ($fell(algRst) && !$past(started, 6));
  c_restart: cover property (state == acr_pkg::ST_RUN && tick && startPend);
  c_done: cover property ($rose(doneFlag));
  c_restart_idle: cover property (state == acr_pkg::ST_IDLE ##[1:50] algRst);

endmodule

// ---- logic/acr_clock_manager.sv ----
`timescale 1ns/1ps
module acr_clock_manager #(
  parameter int DIV_RATIO   = 1,
  parameter int LOCK_CYCLES = acr_pkg::LOCK_CYCLES_DEF
) (
  // clock and asynchronous manager reset
  input  wire logic ref_clk,
  input  wire logic portResetIn,
  // lock and phase ticks
  output logic      locked,
  output logic      undivTick,
  output logic      divTick
);

  localparam int LW = $clog2(LOCK_CYCLES + 1);
  localparam int DW = $clog2(DIV_RATIO + 1);

  if (DIV_RATIO < 1 || DIV_RATIO > 4 || LOCK_CYCLES < 2) begin : g_bad
    $error("acr_clock_manager: unsupported parameters");
  end

  logic [LW-1:0] lockCnt;
  logic [LW-1:0] next_lockCnt;
  logic [DW-1:0] divCnt;
  logic [DW-1:0] next_divCnt;
  logic          next_locked;
  logic          next_divTick;
  logic          next_undivTick;

  // ----------------------------------------------------------------
  // lock model and divider
  // ----------------------------------------------------------------
  always_comb begin
    next_lockCnt   = lockCnt;
    next_locked    = locked;
    if (!locked) begin
      next_lockCnt = lockCnt + 1'b1;
      next_locked  = (lockCnt == LW'(LOCK_CYCLES - 1));
    end
    // divider starts at the lock, so every divided edge is an undivided edge
    if (!locked || divCnt == DW'(DIV_RATIO - 1)) begin
      next_divCnt = '0;
    end else begin
      next_divCnt = divCnt + 1'b1;
    end
    next_divTick   = locked && (next_divCnt == '0);
    next_undivTick = locked;
  end

  // the pin reset acts without the clock
  always_ff @(posedge ref_clk or posedge portResetIn) begin
    if (portResetIn) begin
      lockCnt   <= '0;
      locked    <= 1'b0;
      divCnt    <= '0;
      divTick   <= 1'b0;
      undivTick <= 1'b0;
    end else begin
      lockCnt   <= next_lockCnt;
      locked    <= next_locked;
      divCnt    <= next_divCnt;
      divTick   <= next_divTick;
      undivTick <= next_undivTick;
    end
  end

endmodule

// ---- logic/acr_pkg.sv ----
package acr_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int              DATA_W            = 32;
  localparam int              ADDR_W            = 8;
  localparam logic [7:0]      CTRL_OFF          = 8'h00;
  localparam logic [7:0]      STATUS_OFF        = 8'h04;
  localparam logic [7:0]      RATE_OFF          = 8'h08;
  localparam int              CTRL_START_BIT    = 0;
  localparam int              CTRL_DONE_CLR_BIT = 1;
  localparam logic [31:0]     REG_RESET         = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int              REF_PERIOD_NS     = 20;
  localparam int              CORE_MHZ          = 200;
  localparam int              ALG_RST_CYCLES    = 4;
  localparam logic [2:0]      ALG_RST_LAST      = 3'(ALG_RST_CYCLES - 1);
  localparam int              LOCK_CYCLES_DEF   = 64;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_HOLD, ST_PULSE, ST_RUN, ST_IDLE} acr_state_type;

  typedef struct packed {
    logic started;
    logic done;
    logic coreRst;
    logic locked;
    logic algRst;
    logic running;
  } acr_status_type;

  localparam int              STATUS_W          = 6;

  // core cycles per algorithm cycle for a build-time rate
  function automatic int div_ratio(input int mhz);
    return CORE_MHZ / mhz;
  endfunction

endpackage

// ---- sim/acr_alg_model.sv ----
`timescale 1ns/1ps
module acr_alg_model (
  // clock and bench reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // from controller
  input  wire logic       algEdge,
  input  wire logic       algRst,
  // run length in algorithm cycles
  input  wire logic [7:0] runLen,
  // to controller
  output logic            algDone
);
  logic [7:0] count;
  logic [7:0] next_count;
  logic       next_algDone;

  // ------------------------------------------
  // run counter, moves on algorithm edges only
  // ------------------------------------------
  // done is a held level until the next reset pulse, as real logic keeps it
  always_comb begin
    next_count   = count;
    next_algDone = algDone;
    if (algEdge) begin
      if (algRst) begin
        next_count   = 8'h00;
        next_algDone = 1'b0;
      end else if (!algDone) begin
        next_count   = count + 8'h01;
        next_algDone = (count + 8'h01 == runLen);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count   <= 8'h00;
      algDone <= 1'b0;
    end else begin
      count   <= next_count;
      algDone <= next_algDone;
    end
  end
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  localparam int RATE = 50;
  localparam int DIV  = acr_pkg::CORE_MHZ / RATE;
  localparam int LOCK = 8;

  logic        ref_clk;
  logic        rst;
  logic        portResetIn;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        algDone;
  logic        algClkEnable;
  logic        algEdge;
  logic        algRst;
  logic        fullRst;
  logic        coreRst;
  logic [7:0]  runLen;
  logic        prevRst;
  int          nFail;
  int          nTests;
  int          gap;
  logic        seen;
  logic        fastDone;
  logic        fastEnable;
  logic        fastEdge;
  logic        fastRst;
  logic [31:0] fastRdata;

  acr_algorithm_clock_reset_control #(.RATE_MHZ(RATE), .LOCK_CYCLES(LOCK)) dut (
    .ref_clk(ref_clk), .rst(rst), .portResetIn(portResetIn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .algDone(algDone), .algClkEnable(algClkEnable), .algEdge(algEdge), .algRst(algRst),
    .fullRst(fullRst), .coreRst(coreRst));

  acr_alg_model model (
    .ref_clk(ref_clk), .rst(rst), .algEdge(algEdge), .algRst(algRst),
    .runLen(runLen), .algDone(algDone));

  // second build at the undivided rate, fed by the same bus and pins
  acr_algorithm_clock_reset_control #(
    .RATE_MHZ(acr_pkg::CORE_MHZ), .LOCK_CYCLES(LOCK)) dut_fast (
    .ref_clk(ref_clk), .rst(rst), .portResetIn(portResetIn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(fastRdata),
    .algDone(fastDone), .algClkEnable(fastEnable), .algEdge(fastEdge), .algRst(fastRst),
    .fullRst(), .coreRst());

  acr_alg_model model_fast (
    .ref_clk(ref_clk), .rst(rst), .algEdge(fastEdge), .algRst(fastRst),
    .runLen(runLen), .algDone(fastDone));

  always #10 ref_clk = ~ref_clk;

  // ------------------------------------------
  // compare and bus tasks
  // ------------------------------------------
  task automatic check_bit(input logic got, input logic exp, input string msg);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("MISMATCH at %0t: %s got %h", $time, msg, got);
    end
  endtask

  task automatic check_count(input int got, input int exp, input string msg);
    nTests++;
    if (got != exp) begin
      nFail++;
      $display("MISMATCH at %0t: %s got %0d", $time, msg, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  // ------------------------------------------
  // alignment monitor
  // ------------------------------------------
  // core tick keeps running while gated, so every gap is a whole multiple
  always @(posedge ref_clk) begin
    if (rst || fullRst || coreRst) begin
      seen = 1'b0;
    end else begin
      if (algRst !== prevRst) check_bit(algEdge, 1'b1, "reset moved off edge");
      if (algEdge === 1'b1) begin
        check_bit(algClkEnable, 1'b1, "edge while gated");
        if (seen) check_count(gap % DIV, 0, "edge off core grid");
        seen = 1'b1;
        gap  = 0;
      end
    end
    gap     = gap + 1;
    prevRst = algRst;
  end

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task automatic wait_release();
    int fullAt;
    int coreAt;
    fullAt = -1;
    coreAt = -1;
    for (int i = 0; i < 300 && coreAt < 0; i++) begin
      @(posedge ref_clk);
      #1;
      if (fullAt < 0 && fullRst === 1'b0) fullAt = i;
      if (coreRst === 1'b0) coreAt = i;
    end
    check_count(coreAt - fullAt, 2, "core reset lag");
    check_bit(algRst, 1'b1, "alg reset held after release");
  endtask

  task automatic start_and_pulse();
    int edges;
    int fastEdges;
    edges     = 0;
    fastEdges = 0;
    reg_write(acr_pkg::CTRL_OFF, 32'h0000_0001);
    for (int i = 0; i < 40 * DIV; i++) begin
      @(posedge ref_clk);
      #1;
      if (fastEdge === 1'b1 && fastRst === 1'b1) begin
        fastEdges++;
        check_bit(fastEnable, 1'b1, "fast gate off in pulse");
      end
      if (algEdge === 1'b1 && algRst === 1'b1) begin
        edges++;
        check_bit(algClkEnable, 1'b1, "gate off in pulse");
      end else if (edges > 0 && algRst !== 1'b1) begin
        break;
      end
    end
    check_count(edges, acr_pkg::ALG_RST_CYCLES, "pulse length");
    check_count(fastEdges, acr_pkg::ALG_RST_CYCLES, "fast pulse length");
    check_bit(algRst, 1'b0, "reset not released");
  endtask

  task automatic wait_done();
    logic [31:0] d;
    int edges;
    edges = 0;
    for (int i = 0; i < 100 * DIV && algClkEnable !== 1'b0; i++) @(posedge ref_clk);
    repeat (10 * DIV) begin
      @(posedge ref_clk);
      #1;
      if (algEdge !== 1'b0) edges++;
    end
    check_count(edges, 0, "clock ran after done");
    check_bit(algRst, 1'b0, "reset after done");
    reg_read(acr_pkg::STATUS_OFF, d);
    check_word(d, 32'h0000_0034, "status after run");
  endtask

  task automatic test_power_up();
    logic [31:0] d;
    repeat (3) @(posedge ref_clk);
    #1;
    check_bit(fullRst, 1'b1, "full reset in rst");
    check_bit(coreRst, 1'b1, "core reset in rst");
    check_bit(algRst, 1'b1, "alg reset in rst");
    check_bit(algClkEnable, 1'b0, "gate in rst");
    repeat (3) @(posedge ref_clk);
    rst         <= 1'b0;
    portResetIn <= 1'b0;
    wait_release();
    reg_read(acr_pkg::RATE_OFF, d);
    check_word(d, 32'(RATE), "rate");
    check_word(fastRdata, 32'(acr_pkg::CORE_MHZ), "fast rate");
    reg_write(8'h0C, 32'h0000_0001);
    reg_read(8'h0C, d);
    check_word(d, 32'h0000_0000, "unmapped");
    reg_read(acr_pkg::CTRL_OFF, d);
    check_word(d, 32'h0000_0000, "ctrl readback");
    reg_read(acr_pkg::STATUS_OFF, d);
    check_word(d, 32'h0000_0006, "status idle");
  endtask

  task automatic test_restart();
    runLen <= 8'h1E;
    start_and_pulse();
    repeat (5 * DIV) @(posedge ref_clk);
    start_and_pulse();
    wait_done();
  endtask

  task automatic test_port_reset();
    int hit;
    logic [31:0] d;
    hit = 0;
    runLen <= 8'h1E;
    start_and_pulse();
    @(posedge ref_clk);
    portResetIn <= 1'b1;
    repeat (4) begin
      @(posedge ref_clk);
      #1;
      if (fullRst === 1'b1) hit = 1;
    end
    check_count(hit, 1, "no full reset");
    repeat (3) @(posedge ref_clk);
    #1;
    check_bit(coreRst, 1'b1, "core reset missing");
    check_bit(algRst, 1'b1, "alg reset missing");
    @(posedge ref_clk);
    portResetIn <= 1'b0;
    wait_release();
    reg_read(acr_pkg::STATUS_OFF, d);
    check_word(d, 32'h0000_0006, "status after port reset");
    runLen <= 8'h03;
    start_and_pulse();
    wait_done();
  endtask

  task automatic wrap_up();
    $display("tests %0d, mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    nFail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    ref_clk     = 1'b0;
    rst         = 1'b1;
    // the manager clears only on the pin, so power up with it asserted
    portResetIn = 1'b1;
    regAddr     = 8'h00;
    regWdata    = 32'h0000_0000;
    regWrite    = 1'b0;
    regRead     = 1'b0;
    runLen      = 8'h03;
    prevRst     = 1'b1;
    nFail       = 0;
    nTests      = 0;
    gap         = 0;
    seen        = 1'b0;
    test_power_up();
    start_and_pulse();
    wait_done();
    test_restart();
    test_port_reset();
    wrap_up();
  end
endmodule
